// *** common/can_wake_pkg.sv ***
package can_wake_pkg;

  // ****************************************
  // Transceiver modes (two mode bits)
  // ****************************************
  localparam logic [1:0] XCVR_OFF       = 2'h0;
  localparam logic [1:0] XCVR_WAKE_CAP  = 2'h1;
  localparam logic [1:0] XCVR_NORMAL    = 2'h2;
  localparam logic [1:0] XCVR_RX_ONLY   = 2'h3;
  localparam int         XCVR_UPPER_BIT = 1;

  // ****************************************
  // Device modes
  // ****************************************
  localparam logic [2:0] DEV_NORMAL    = 3'h0;
  localparam logic [2:0] DEV_STOP      = 3'h1;
  localparam logic [2:0] DEV_SLEEP     = 3'h2;
  localparam logic [2:0] DEV_RESTART   = 3'h3;
  localparam logic [2:0] DEV_FAIL_SAFE = 3'h4;

  // ****************************************
  // Termination selection
  // ****************************************
  localparam logic [1:0] TERM_FLOAT = 2'h0;
  localparam logic [1:0] TERM_HALF  = 2'h1;
  localparam logic [1:0] TERM_GND   = 2'h2;
  localparam logic [1:0] TERM_2V5   = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ      = 50_000_000;
  localparam int TX_TIMEOUT_US    = 2000;
  localparam int BUS_TIMEOUT_US   = 2600;
  localparam int SILENCE_US       = 1000;
  localparam int RESTART_HOLD_US  = 10;
  localparam int TX_TIMEOUT_CYC   = TX_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int BUS_TIMEOUT_CYC  = BUS_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SILENCE_CYC      = SILENCE_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int RESTART_HOLD_CYC = RESTART_HOLD_US * (CLK_FREQ_HZ / 1_000_000);

  // ****************************************
  // Wake event FIFO
  // ****************************************
  localparam int EVT_WIDTH = 3;
  localparam int EVT_DEPTH = 4;

endpackage

// *** common/wake_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface wake_evt_if #(parameter int WIDTH = 3);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/dom_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dom_timer #(
  parameter int LIMIT = 100
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_cond,
  output logic      o_expired
);
  logic [31:0] count_reg;

  // Restart whenever the qualifying condition drops
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_cond) begin
      count_reg <= 32'h0;
    end else if (count_reg < 32'(LIMIT)) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  assign o_expired = i_cond && (count_reg >= 32'(LIMIT));
endmodule
`default_nettype wire

// *** rtl/evt_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module evt_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  wake_evt_if.dst   in_port,
  wake_evt_if.src   out_port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_port.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_port.valid = (cnt_reg != '0);
  assign out_port.data  = mem_reg[rd_reg];
  assign push = in_port.valid && in_port.ready;
  assign pop  = out_port.valid && out_port.ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_port.data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** rtl/can_wake_fault_ctrl.sv ***
// Contract
// - Stop/Normal wake: interrupt low, status, receive low
// - Stop wake keeps device in Stop
// - Stop wake enables watchdog if configured
// - Sleep wake goes Restart then Normal
// - No interrupt when leaving Sleep
// - Restart/Fail-Safe wake: Restart, receive low
// - Termination chosen per transceiver mode
// - Ground termination only after silence time
// - Transmit time-out disables transmitter, bus recessive
// - Transmit time-out: mode kept, failure flagged
// - Transmit recovers when input goes recessive
// - Bus dominant too long flags failure
// - Clamping leaves transceiver mode unchanged
// - Bus filter longer than transmit time-out
// - Undervoltage sets flag, disables transmitter
// - Supply recovery restores normal transmission
// - Undervoltage detection only when upper bit set
// - After wake mode reads wake-capable, receive low
// - Off mode ignores bus wake-ups
`timescale 1ns/1ps
`default_nettype none
module can_wake_fault_ctrl
  import can_wake_pkg::*;
#(
  parameter int TX_TO_CYC   = TX_TIMEOUT_CYC,
  parameter int BUS_TO_CYC  = BUS_TIMEOUT_CYC,
  parameter int SILENCE_CY  = SILENCE_CYC,
  parameter int RESTART_CY  = RESTART_HOLD_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_xcvr_mode,
  input  wire logic       i_dev_mode_wr,
  input  wire logic [2:0] i_dev_mode_cmd,
  input  wire logic       i_watchdog_on_bus_wake,
  input  wire logic       i_watchdog_en_wr,
  input  wire logic       i_watchdog_en_val,
  input  wire logic       i_transmit_line,
  input  wire logic       i_bus_dominant,
  input  wire logic       i_bus_rx_data,
  input  wire logic       i_bus_wake,
  input  wire logic       i_transceiver_supply_low,
  input  wire logic       i_fail_clear,
  input  wire logic       i_uv_clear,
  input  wire logic       i_wake_clear,
  input  wire logic       i_evt_ready,
  output logic            o_receive_line,
  output logic            o_interrupt_out_low,
  output logic            o_wake_status_reg,
  output logic            o_bus_fail_flag,
  output logic            o_supply_undervolt_flag,
  output logic            o_tx_enable,
  output logic            o_tx_dominant,
  output logic [1:0]      o_termination,
  output logic [2:0]      o_dev_mode,
  output logic            o_watchdog_en,
  output logic            o_evt_valid,
  output logic [2:0]      o_evt_data,
  output logic            o_wake_dropped
);

  // ****************************************
  // Device mode and wake state
  // ****************************************
  typedef enum {ST_NORMAL, ST_STOP, ST_SLEEP, ST_RESTART, ST_FAIL_SAFE} dev_state_t;

  dev_state_t  state_reg;
  dev_state_t  state_next;
  logic        woken_reg;
  logic        wake_status_reg;
  logic        irq_reg;
  logic        wd_reg;
  logic [1:0]  mode_prev_reg;
  logic [31:0] restart_cnt_reg;
  logic        fail_reg;
  logic        uv_reg;
  logic        rx_reg;
  logic        drop_reg;
  logic        wake_ev;
  logic        uv_active;
  logic        tx_to;
  logic        bus_clamp;
  logic        silence_done;
  logic        restart_done;

  function automatic dev_state_t decode_mode(input logic [2:0] m);
    case (m)
      DEV_NORMAL:    decode_mode = ST_NORMAL;
      DEV_STOP:      decode_mode = ST_STOP;
      DEV_SLEEP:     decode_mode = ST_SLEEP;
      DEV_RESTART:   decode_mode = ST_RESTART;
      default:       decode_mode = ST_FAIL_SAFE;
    endcase
  endfunction

  // Wake only counts in wake-capable mode and only once until the transceiver is rearmed
  // Off ignores wakes
  assign wake_ev = i_bus_wake && (i_xcvr_mode == XCVR_WAKE_CAP) && !woken_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || state_reg != ST_RESTART) begin
      restart_cnt_reg <= 32'h0;
    end else if (restart_cnt_reg < 32'(RESTART_CY)) begin
      restart_cnt_reg <= restart_cnt_reg + 32'h1;
    end
  end
  assign restart_done = (restart_cnt_reg >= 32'(RESTART_CY));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STOP:      state_next = ST_STOP;
      ST_SLEEP:     state_next = wake_ev ? ST_RESTART : ST_SLEEP;
      ST_RESTART:   state_next = restart_done ? ST_NORMAL : ST_RESTART;
      ST_FAIL_SAFE: state_next = wake_ev ? ST_RESTART : ST_FAIL_SAFE;
      ST_NORMAL:    state_next = ST_NORMAL;
      default:      state_next = ST_NORMAL;
    endcase
    if (i_dev_mode_wr) begin
      state_next = decode_mode(i_dev_mode_cmd);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    case (state_reg)
      ST_NORMAL:  o_dev_mode = DEV_NORMAL;
      ST_STOP:    o_dev_mode = DEV_STOP;
      ST_SLEEP:   o_dev_mode = DEV_SLEEP;
      ST_RESTART: o_dev_mode = DEV_RESTART;
      default:    o_dev_mode = DEV_FAIL_SAFE;
    endcase
  end

  // ****************************************
  // Wake latch and rearm
  // ****************************************
  // Woken holds until mode changes; Stop/Sleep/Fail-Safe entry rearms
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      woken_reg     <= 1'b0;
      mode_prev_reg <= XCVR_OFF;
    end else begin
      mode_prev_reg <= i_xcvr_mode;
      if (wake_ev) begin
        woken_reg <= 1'b1;
      end else if (i_xcvr_mode != XCVR_WAKE_CAP) begin
        woken_reg <= 1'b0;
      end else if (i_dev_mode_wr && decode_mode(i_dev_mode_cmd) inside {ST_STOP, ST_SLEEP, ST_FAIL_SAFE}) begin
        woken_reg <= 1'b0;
      end
    end
  end

  // Wake status, set wins over clear
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wake_status_reg <= 1'b0;
    end else if (wake_ev) begin
      wake_status_reg <= 1'b1;
    end else if (i_wake_clear) begin
      wake_status_reg <= 1'b0;
    end
  end

  // Interrupt only from Stop or Normal
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_reg <= 1'b0;
    end else if (wake_ev && (state_reg == ST_STOP || state_reg == ST_NORMAL)) begin
      irq_reg <= 1'b1;
    end else if (i_wake_clear) begin
      irq_reg <= 1'b0;
    end
  end
  assign o_interrupt_out_low = !irq_reg;
  assign o_wake_status_reg   = wake_status_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wd_reg <= 1'b0;
    end else if (wake_ev && state_reg == ST_STOP && i_watchdog_on_bus_wake) begin
      wd_reg <= 1'b1;
    end else if (i_watchdog_en_wr) begin
      wd_reg <= i_watchdog_en_val;
    end
  end
  assign o_watchdog_en = wd_reg;

  // ****************************************
  // Fault timers
  // ****************************************
  // Bus filter must exceed transmit time-out
  localparam int BUS_LIMIT = (BUS_TO_CYC > TX_TO_CYC) ? BUS_TO_CYC : TX_TO_CYC + 1;

  dom_timer #(.LIMIT(TX_TO_CYC)) u_tx_timer (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_cond    (!i_transmit_line && i_xcvr_mode == XCVR_NORMAL),
    .o_expired (tx_to)
  );

  dom_timer #(.LIMIT(BUS_LIMIT)) u_bus_timer (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_cond    (i_bus_dominant && i_xcvr_mode[XCVR_UPPER_BIT]),
    .o_expired (bus_clamp)
  );

  dom_timer #(.LIMIT(SILENCE_CY)) u_silence (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_cond    (i_xcvr_mode == XCVR_WAKE_CAP && !i_bus_dominant),
    .o_expired (silence_done)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fail_reg <= 1'b0;
    end else if (tx_to || bus_clamp) begin
      fail_reg <= 1'b1;
    end else if (i_fail_clear) begin
      fail_reg <= 1'b0;
    end
  end
  assign o_bus_fail_flag = fail_reg;

  assign uv_active = i_xcvr_mode[XCVR_UPPER_BIT] && i_transceiver_supply_low;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      uv_reg <= 1'b0;
    end else if (uv_active) begin
      uv_reg <= 1'b1;
    end else if (i_uv_clear) begin
      uv_reg <= 1'b0;
    end
  end
  assign o_supply_undervolt_flag = uv_reg;

  assign o_tx_enable   = (i_xcvr_mode == XCVR_NORMAL) && !tx_to && !uv_active;
  assign o_tx_dominant = o_tx_enable && !i_transmit_line;

  always_comb begin
    case (i_xcvr_mode)
      XCVR_NORMAL:   o_termination = TERM_HALF;
      XCVR_RX_ONLY:  o_termination = uv_active ? TERM_2V5 : TERM_HALF;
      XCVR_WAKE_CAP: o_termination = woken_reg ? TERM_2V5 : (silence_done ? TERM_GND : TERM_FLOAT);
      default:       o_termination = TERM_FLOAT;
    endcase
  end

  // ****************************************
  // Receive line
  // ****************************************
  // Receive low after wake
  // Receive low after wake in Restart and Fail-Safe as well; the device mode does not gate the line
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rx_reg <= 1'b1;
    end else if (i_xcvr_mode == XCVR_WAKE_CAP) begin
      // Rearm by a device mode change clears woken but must not release the line
      rx_reg <= !(woken_reg || wake_ev || (mode_prev_reg == XCVR_WAKE_CAP && !rx_reg));
    end else if (i_xcvr_mode[XCVR_UPPER_BIT]) begin
      rx_reg <= i_bus_rx_data;
    end else begin
      rx_reg <= 1'b1;
    end
  end
  assign o_receive_line = rx_reg;

  // ****************************************
  // Wake event log
  // ****************************************
  // Events record the device mode at wake; a full log drops and flags, it never stalls detection
  wake_evt_if #(.WIDTH(EVT_WIDTH)) evt_in ();
  wake_evt_if #(.WIDTH(EVT_WIDTH)) evt_out ();

  assign evt_in.valid  = wake_ev;
  assign evt_in.data   = o_dev_mode;
  assign evt_out.ready = i_evt_ready;

  evt_fifo #(.WIDTH(EVT_WIDTH), .DEPTH(EVT_DEPTH)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .in_port   (evt_in),
    .out_port  (evt_out)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      drop_reg <= 1'b0;
    end else if (wake_ev && !evt_in.ready) begin
      drop_reg <= 1'b1;
    end else if (i_wake_clear) begin
      drop_reg <= 1'b0;
    end
  end

  assign o_evt_valid    = evt_out.valid;
  assign o_evt_data     = evt_out.data;
  assign o_wake_dropped = drop_reg;

endmodule
`default_nettype wire

// *** tb/can_wake_fault_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_wake_fault_ctrl_props
  import can_wake_pkg::*;
#(
  parameter int TX_TO_CYC  = 8,
  parameter int BUS_TO_CYC = 12,
  parameter int SILENCE_CY = 5
) (
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic [1:0] i_xcvr_mode,
  input wire logic       i_dev_mode_wr,
  input wire logic       i_watchdog_on_bus_wake,
  input wire logic       i_watchdog_en_wr,
  input wire logic       i_transmit_line,
  input wire logic       i_bus_dominant,
  input wire logic       i_bus_wake,
  input wire logic       i_transceiver_supply_low,
  input wire logic       o_receive_line,
  input wire logic       o_interrupt_out_low,
  input wire logic       o_wake_status_reg,
  input wire logic       o_bus_fail_flag,
  input wire logic       o_supply_undervolt_flag,
  input wire logic       o_tx_enable,
  input wire logic       o_tx_dominant,
  input wire logic [1:0] o_termination,
  input wire logic [2:0] o_dev_mode,
  input wire logic       o_watchdog_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic       armed;
  logic [7:0] tcnt_reg;
  logic [7:0] bcnt_reg;
  logic [7:0] mcnt_reg;
  // Receive line still high means the wake path is armed
  assign armed = i_bus_wake && !i_dev_mode_wr && i_xcvr_mode == XCVR_WAKE_CAP && o_receive_line;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_xcvr_mode != XCVR_NORMAL || i_transmit_line) tcnt_reg <= 8'h00;
    else if (tcnt_reg != 8'hff) tcnt_reg <= tcnt_reg + 8'h01;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_xcvr_mode[XCVR_UPPER_BIT] || !i_bus_dominant) bcnt_reg <= 8'h00;
    else if (bcnt_reg != 8'hff) bcnt_reg <= bcnt_reg + 8'h01;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_xcvr_mode != XCVR_WAKE_CAP) mcnt_reg <= 8'h00;
    else if (mcnt_reg != 8'hff) mcnt_reg <= mcnt_reg + 8'h01;
  end
  AST_STOP_WAKE: assert property (armed && o_dev_mode == DEV_STOP |=>
    !o_interrupt_out_low && o_wake_status_reg && !o_receive_line && o_dev_mode == DEV_STOP) else $error("stop wake");
  AST_WD_WAKE: assert property (armed && o_dev_mode == DEV_STOP && i_watchdog_on_bus_wake &&
    !i_watchdog_en_wr |=> o_watchdog_en) else $error("watchdog not enabled");
  AST_SLEEP_WAKE: assert property (armed && o_dev_mode == DEV_SLEEP && o_interrupt_out_low |=>
    o_interrupt_out_low && o_dev_mode == DEV_RESTART) else $error("sleep wake");
  AST_FS_WAKE: assert property (armed && o_dev_mode == DEV_FAIL_SAFE && o_interrupt_out_low |=>
    o_interrupt_out_low && !o_receive_line && o_dev_mode == DEV_RESTART) else $error("fail-safe wake");
  AST_RX_HELD: assert property (!o_receive_line && i_xcvr_mode == XCVR_WAKE_CAP && !i_dev_mode_wr
    && $past(i_xcvr_mode) == XCVR_WAKE_CAP ##1 i_xcvr_mode == XCVR_WAKE_CAP |-> !o_receive_line)
    else $error("receive line released");
  AST_OFF_IGNORE: assert property (i_xcvr_mode == XCVR_OFF && !o_wake_status_reg |=>
    !o_wake_status_reg) else $error("wake in off mode");
  AST_TERM_HALF: assert property (i_xcvr_mode == XCVR_NORMAL |->
    o_termination == TERM_HALF) else $error("normal termination");
  AST_GND_SILENCE: assert property (o_termination == TERM_GND |->
    mcnt_reg >= SILENCE_CY - 1) else $error("ground too early");
  AST_TX_TIMEOUT: assert property (tcnt_reg >= TX_TO_CYC + 2 && !i_transmit_line |->
    !o_tx_enable && !o_tx_dominant && o_bus_fail_flag) else $error("tx time-out");
  AST_TX_OK: assert property (i_xcvr_mode == XCVR_NORMAL && !i_transceiver_supply_low &&
    !$past(i_transceiver_supply_low) && tcnt_reg < TX_TO_CYC - 2 |-> o_tx_enable) else $error("tx off");
  AST_CLAMP: assert property (bcnt_reg >= BUS_TO_CYC + 2 |-> o_bus_fail_flag) else $error("clamp");
  AST_UV: assert property ((i_transceiver_supply_low && i_xcvr_mode[XCVR_UPPER_BIT])[*2] |->
    o_supply_undervolt_flag && !o_tx_enable) else $error("undervoltage");
  AST_UV_OFF: assert property (!i_xcvr_mode[XCVR_UPPER_BIT] && !o_supply_undervolt_flag |=>
    !o_supply_undervolt_flag) else $error("uv outside detection");
  cover property (armed && o_dev_mode == DEV_STOP);
  cover property (armed && o_dev_mode == DEV_SLEEP);
  cover property (bcnt_reg == BUS_TO_CYC + 2);
endmodule
`default_nettype wire

// *** tb/can_bus_node.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side: bus with other nodes
// ****************************************
module can_bus_node (
  input  wire logic i_ref_clk,
  input  wire logic i_wake_req,
  input  wire logic i_clamp_req,
  input  wire logic i_tx_dominant,
  output logic      o_bus_wake,
  output logic      o_bus_dominant,
  output logic      o_bus_rx_data
);
  // Wired bus: any dominant driver wins, receiver sees inverse
  assign o_bus_dominant = i_tx_dominant | i_clamp_req;
  assign o_bus_rx_data  = !o_bus_dominant;
  always_ff @(posedge i_ref_clk) begin
    o_bus_wake <= i_wake_req;
  end
endmodule
`default_nettype wire

// *** tb/can_wake_fault_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_wake_fault_ctrl_tb;
  import can_wake_pkg::*;
  typedef struct packed {logic [1:0] m; logic u; logic [1:0] t; logic f;} row_t;
  localparam int TX_TO_CYC = 8, BUS_TO_CYC = 12, SILENCE_CY = 5;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, wdb = 1'b0, wdw = 1'b0, txl = 1'b1, uv = 1'b0;
  logic fc = 1'b0, uc = 1'b0, wc = 1'b0, rdy = 1'b0, wreq = 1'b0, creq = 1'b0;
  logic [1:0] xm = XCVR_OFF;
  logic [2:0] cmd = DEV_NORMAL;
  logic rxl, int_low, wst, bfail, uvf, txen, txd, wden, ev, drop, bwake, bdom, brx;
  logic [1:0] term;
  logic [2:0] dm, ed;
  int n_fail = 0, check_count = 0;
  row_t rows [6] = '{'{XCVR_OFF, 1'b1, TERM_FLOAT, 1'b0}, '{XCVR_WAKE_CAP, 1'b0, TERM_GND, 1'b0},
    '{XCVR_NORMAL, 1'b0, TERM_HALF, 1'b0}, '{XCVR_NORMAL, 1'b1, TERM_HALF, 1'b1},
    '{XCVR_RX_ONLY, 1'b0, TERM_HALF, 1'b0}, '{XCVR_RX_ONLY, 1'b1, TERM_2V5, 1'b1}};
  logic [2:0] exp_log [4] = '{DEV_STOP, DEV_NORMAL, DEV_SLEEP, DEV_FAIL_SAFE};
  can_wake_fault_ctrl #(.TX_TO_CYC(TX_TO_CYC), .BUS_TO_CYC(BUS_TO_CYC), .SILENCE_CY(SILENCE_CY),
    .RESTART_CY(3)) i_dut (.i_ref_clk(clk), .i_reset(rst), .i_xcvr_mode(xm), .i_dev_mode_wr(wr),
    .i_dev_mode_cmd(cmd), .i_watchdog_on_bus_wake(wdb), .i_watchdog_en_wr(wdw), .i_watchdog_en_val(1'b0),
    .i_transmit_line(txl), .i_bus_dominant(bdom), .i_bus_rx_data(brx), .i_bus_wake(bwake),
    .i_transceiver_supply_low(uv), .i_fail_clear(fc), .i_uv_clear(uc), .i_wake_clear(wc), .i_evt_ready(rdy),
    .o_receive_line(rxl), .o_interrupt_out_low(int_low), .o_wake_status_reg(wst), .o_bus_fail_flag(bfail),
    .o_supply_undervolt_flag(uvf), .o_tx_enable(txen), .o_tx_dominant(txd), .o_termination(term),
    .o_dev_mode(dm), .o_watchdog_en(wden), .o_evt_valid(ev), .o_evt_data(ed), .o_wake_dropped(drop));
  can_bus_node i_node (.i_ref_clk(clk), .i_wake_req(wreq), .i_clamp_req(creq), .i_tx_dominant(txd),
    .o_bus_wake(bwake), .o_bus_dominant(bdom), .o_bus_rx_data(brx));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t ns output mismatch", $time);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Inputs move 1 ns after the edge, outputs are settled then
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wake();
    pulse(wreq);
    cyc(1);
  endtask
  task automatic mode(input logic [2:0] m);
    cmd = m;
    pulse(wr);
  endtask
  // Leaving wake-capable and coming back rearms the wake path
  task automatic rearm();
    xm = XCVR_OFF;
    cyc(1);
    xm = XCVR_WAKE_CAP;
    cyc(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    cyc(20);
    rst = 1'b0;
    chk(int_low === 1'b1 && rxl === 1'b1 && wden === 1'b0 && wst === 1'b0 && bfail === 1'b0 && ev === 1'b0);
    foreach (rows[i]) begin
      xm = rows[i].m;
      uv = rows[i].u;
      cyc(10);
      chk(term === rows[i].t && uvf === rows[i].f);
      uv = 1'b0;
      xm = XCVR_OFF;
      pulse(uc);
    end
    xm = XCVR_WAKE_CAP;
    cyc(2);
    chk(term === TERM_FLOAT);
    xm = XCVR_OFF;
    wake();
    chk(wst === 1'b0 && int_low === 1'b1);
    wdb = 1'b1;
    pulse(wdw);
    mode(DEV_STOP);
    xm = XCVR_WAKE_CAP;
    wake();
    chk(int_low === 1'b0 && wst === 1'b1 && rxl === 1'b0 && wden === 1'b1);
    chk(term === TERM_2V5 && ev === 1'b1 && ed === DEV_STOP);
    cyc(5);
    chk(dm === DEV_STOP && rxl === 1'b0);
    // Controller takes the device out of stop itself
    pulse(wc);
    mode(DEV_NORMAL);
    rearm();
    wake();
    chk(int_low === 1'b0 && dm === DEV_NORMAL && rxl === 1'b0);
    pulse(wc);
    rearm();
    mode(DEV_SLEEP);
    wake();
    chk(int_low === 1'b1 && dm === DEV_RESTART);
    cyc(5);
    chk(dm === DEV_NORMAL && rxl === 1'b0 && wst === 1'b1);
    rearm();
    mode(DEV_FAIL_SAFE);
    wake();
    chk(dm === DEV_RESTART && int_low === 1'b1 && rxl === 1'b0 && drop === 1'b0);
    cyc(5);
    rearm();
    // Wake lands while restart is still held, the log is full by now
    wreq = 1'b1;
    mode(DEV_RESTART);
    wreq = 1'b0;
    cyc(1);
    chk(dm === DEV_RESTART && int_low === 1'b1 && drop === 1'b1);
    rdy = 1'b1;
    foreach (exp_log[i]) begin
      chk(ev === 1'b1 && ed === exp_log[i]);
      cyc(1);
    end
    chk(ev === 1'b0);
    xm = XCVR_NORMAL;
    pulse(fc);
    txl = 1'b0;
    cyc(2);
    chk(txd === 1'b1 && txen === 1'b1);
    cyc(18);
    chk(txen === 1'b0 && txd === 1'b0 && bfail === 1'b1 && term === TERM_HALF);
    txl = 1'b1;
    cyc(1);
    chk(txen === 1'b1);
    xm = XCVR_RX_ONLY;
    pulse(fc);
    for (int k = 0; k < 2; k++) begin
      creq = 1'b1;
      cyc(BUS_TO_CYC - 2);
      creq = 1'b0;
      cyc(1);
    end
    chk(bfail === 1'b0);
    creq = 1'b1;
    cyc(20);
    creq = 1'b0;
    chk(bfail === 1'b1 && term === TERM_HALF);
    xm = XCVR_NORMAL;
    uv = 1'b1;
    cyc(3);
    chk(txen === 1'b0 && uvf === 1'b1);
    uv = 1'b0;
    cyc(2);
    chk(txen === 1'b1);
    // Reset in mid-run must clear every sticky flag and the log
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk(bfail === 1'b0 && uvf === 1'b0 && wden === 1'b0 && drop === 1'b0 && dm === DEV_NORMAL);
    chk(int_low === 1'b1 && wst === 1'b0 && ev === 1'b0 && rxl === 1'b1);
    end_of_test();
  end
endmodule
bind can_wake_fault_ctrl can_wake_fault_ctrl_props #(.TX_TO_CYC(TX_TO_CYC), .BUS_TO_CYC(BUS_TO_CYC),
  .SILENCE_CY(SILENCE_CY)) i_props (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_xcvr_mode(i_xcvr_mode),
  .i_dev_mode_wr(i_dev_mode_wr), .i_watchdog_on_bus_wake(i_watchdog_on_bus_wake),
  .i_watchdog_en_wr(i_watchdog_en_wr), .i_transmit_line(i_transmit_line), .i_bus_dominant(i_bus_dominant),
  .i_bus_wake(i_bus_wake), .i_transceiver_supply_low(i_transceiver_supply_low),
  .o_receive_line(o_receive_line), .o_interrupt_out_low(o_interrupt_out_low),
  .o_wake_status_reg(o_wake_status_reg), .o_bus_fail_flag(o_bus_fail_flag),
  .o_supply_undervolt_flag(o_supply_undervolt_flag), .o_tx_enable(o_tx_enable),
  .o_tx_dominant(o_tx_dominant), .o_termination(o_termination), .o_dev_mode(o_dev_mode),
  .o_watchdog_en(o_watchdog_en));
`default_nettype wire
